// >>> rtl/gsd_controller.sv
`timescale 1ns/10ps
module gsd_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 4
) (
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] slot [DEPTH];
   logic [PW-1:0]    wp_r;
   logic [PW-1:0]    rp_r;
   logic [PW:0]      cnt_r;

   wire push = inValid && inReady;
   wire pop  = outValid && outReady;

   assign inReady  = (cnt_r != DEPTH[PW:0]);
   assign outValid = (cnt_r != '0);
   assign outData  = slot[rp_r];

   always_ff @(posedge ref_clk) begin
      if (push) begin
         slot[wp_r] <= inData;
      end
   end

   // pointers wrap naturally since depth is a power of two
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         wp_r  <= wp_r + PW'(push);
         rp_r  <= rp_r + PW'(pop);
         cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule

module gsd_controller
   import gsd_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rstn,
   gsd_link_if.ctrl               link,
   input  wire logic              mirrorStrap,
   input  wire logic              reqValid,
   output logic                   reqReady,
   input  wire logic              reqWrite,
   input  wire logic [BANK_W-1:0] reqBank,
   input  wire logic [ADDR_W-1:0] reqRow,
   input  wire logic [8:0]        reqCol,
   input  wire logic [PAIR_W-1:0] reqWData,
   input  wire logic [MASK_W-1:0] reqMask,
   output logic                   rdValid,
   input  wire logic              rdReady,
   output logic [PAIR_W-1:0]      rdData,
   input  wire logic              powerDownReq,
   input  wire logic              selfRefreshReq,
   output logic                   busy
);

   typedef enum logic [2:0] {
      GSD_C_INIT, GSD_C_IDLE, GSD_C_ACCESS, GSD_C_BEAT, GSD_C_DONE, GSD_C_PD, GSD_C_SR
   } gsd_cstate_t;

   gsd_cstate_t          st_r;
   gsd_cstate_t          st_nxt;
   logic [3:0]           cmd_r;
   logic [BANK_W-1:0]    bank_r;
   logic [ADDR_W-1:0]    addr_r;
   logic                 cke_r;
   logic                 write_r;
   logic [8:0]           col_r;
   logic [PAIR_W-1:0]    wdata_r;
   logic [MASK_W-1:0]    mask_r;
   logic                 dqOe_r;
   logic                 fifoInReady;

   // a read is only taken while the buffer has room for its pair
   wire accept   = (st_r == GSD_C_IDLE) && reqValid && !selfRefreshReq && !powerDownReq
                   && (reqWrite || fifoInReady);
   wire capture  = (st_r == GSD_C_DONE) && !write_r && link.dqDevOe;
   wire [ADDR_W-1:0] colWord = {2'h0, col_r[8], 1'b1, col_r[7:0]};

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         GSD_C_INIT:   st_nxt = GSD_C_IDLE;
         GSD_C_IDLE: begin
            if (selfRefreshReq) begin
               st_nxt = GSD_C_SR;
            end else if (powerDownReq) begin
               st_nxt = GSD_C_PD;
            end else if (accept) begin
               st_nxt = GSD_C_ACCESS;
            end
         end
         GSD_C_ACCESS: st_nxt = GSD_C_BEAT;
         GSD_C_BEAT:   st_nxt = GSD_C_DONE;
         GSD_C_DONE:   st_nxt = GSD_C_IDLE;
         GSD_C_PD:     st_nxt = powerDownReq ? GSD_C_PD : GSD_C_IDLE;
         GSD_C_SR:     st_nxt = selfRefreshReq ? GSD_C_SR : GSD_C_IDLE;
         default:      st_nxt = GSD_C_IDLE;
      endcase
   end

   // registered pins; clock enable only drops from idle
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_r  <= GSD_C_INIT;
         cmd_r <= CMD_NOP;
         cke_r <= 1'b1;
      end else begin
         st_r  <= st_nxt;
         cke_r <= !(st_nxt == GSD_C_PD || st_nxt == GSD_C_SR);
         case (st_r)
            GSD_C_INIT:   cmd_r <= CMD_MRS;
            GSD_C_IDLE:   cmd_r <= (st_nxt == GSD_C_SR) ? CMD_REF :
                                   (accept ? CMD_ACT : CMD_NOP);
            GSD_C_ACCESS: cmd_r <= write_r ? CMD_WR : CMD_RD;
            default:      cmd_r <= CMD_NOP;
         endcase
      end
   end

   // bank and data held for the whole access; address moves from row to column
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         bank_r  <= '0;
         addr_r  <= '0;
         write_r <= 1'b0;
         col_r   <= '0;
         wdata_r <= '0;
         mask_r  <= '0;
         dqOe_r  <= 1'b0;
      end else begin
         // data goes out the clock after the write command is sampled
         dqOe_r <= (st_r == GSD_C_BEAT) && write_r;
         if (st_r == GSD_C_INIT) begin
            addr_r <= INIT_OP;
         end else if (accept) begin
            bank_r  <= reqBank;
            addr_r  <= reqRow;
            write_r <= reqWrite;
            col_r   <= reqCol;
            wdata_r <= reqWData;
            mask_r  <= reqMask;
         end else if (st_r == GSD_C_ACCESS) begin
            addr_r <= colWord;                                            // auto-precharge set
         end
      end
   end

   // single clock stays running; self refresh is the only stop window
   assign link.cke           = cke_r;
   assign link.csN           = cmd_r[3];
   assign link.mirrorSelect  = mirrorStrap;
   assign link.rasN          = mirrorStrap ? 1'b0 : cmd_r[2];
   assign link.spareRx       = mirrorStrap ? cmd_r[2] : 1'b0;
   assign link.casN          = cmd_r[1];
   assign link.weN           = cmd_r[0];
   assign link.bankSelect    = bank_r;
   assign link.addr          = addr_r;
   assign link.dqCtrl        = wdata_r;
   assign link.dqCtrlOe      = dqOe_r;
   assign link.writeByteMask = dqOe_r ? mask_r : '0;
   assign link.writeStrobe   = dqOe_r ? STRB_BEAT : '0;

   assign reqReady = accept;
   assign busy     = (st_r != GSD_C_IDLE);

   // read pairs queue here; a stalled consumer blocks new reads
   gsd_fifo #(
      .WIDTH (PAIR_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rdq (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .inValid  (capture),
      .inReady  (fifoInReady),
      .inData   (link.dqBus),
      .outValid (rdValid),
      .outReady (rdReady),
      .outData  (rdData)
   );

endmodule

// >>> include/gsd_pkg.sv
// Functional notes
// - Command and address captured at rising clock only
// - Read data carries two beats per clock
// - Clock enable low stops buffers and drivers
// - Clock enable drop picks power-down or self refresh
// - Clock enable sync, except self-refresh exit; device samples that exit on the rising edge too
// - Controller keeps clock enable high during accesses
// - Power-down ignores all inputs but clock enable
// - Controller keeps clock running outside self refresh
// - Chip select high masks every command
// - Command from select and three strobes together
// - Masked write bytes are not stored
// - Bank select picks the target bank
// - Row address twelve bits; column bit 8 auto-precharge
// - Precharge bit 8 chooses one or all banks
// - Mode set takes op-code from address
// - Mirror select swaps row strobe and spare receiver
// - Four independent banks
// - Read strobe edges aligned with read data
package gsd_pkg;

   localparam int ADDR_W     = 12;
   localparam int BANKS      = 4;
   localparam int BANK_W     = 2;
   localparam int BEAT_W     = 32;
   localparam int PAIR_W     = 2 * BEAT_W;   // rising beat low half, falling beat high half
   localparam int MASK_W     = 8;            // byte masks, rising beat in bits 3..0
   localparam int STRB_W     = 8;
   localparam int MEM_IDX_W  = 7;
   localparam int MEM_WORDS  = 128;
   localparam int FIFO_DEPTH = 4;

   localparam int SCOPE_BIT   = 8;           // precharge_scope_bit / auto_precharge_flag
   localparam int COL_HI_BIT  = 9;

   // {chip select, row strobe, column strobe, write enable}, all active low
   localparam logic [3:0] CMD_MRS = 4'h0;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_WR  = 4'h4;
   localparam logic [3:0] CMD_RD  = 4'h5;
   localparam logic [3:0] CMD_NOP = 4'h7;

   localparam logic [ADDR_W-1:0] MODE_RST  = 12'h000;
   localparam logic [ADDR_W-1:0] INIT_OP   = 12'h031;  // arbitrary start-up op-code, not the reset value
   localparam logic [STRB_W-1:0] STRB_BEAT = 8'h0f;  // high on rising beat, low on falling

   typedef enum logic [1:0] {
      GSD_PS_NORMAL,
      GSD_PS_PRE_PD,
      GSD_PS_ACT_PD,
      GSD_PS_SELF_REF
   } gsd_power_t;

   // word pair base inside the small storage array
   function automatic logic [MEM_IDX_W-1:0] gsd_mem_index(input logic [BANK_W-1:0] bank,
                                                           input logic [ADDR_W-1:0] row,
                                                           input logic [ADDR_W-1:0] col);
      gsd_mem_index = {bank, row[1:0], col[2:1], 1'b0};
   endfunction

endpackage

// >>> include/gsd_link_if.sv
`timescale 1ns/10ps
interface gsd_link_if (
   input wire logic ref_clk
);
   import gsd_pkg::*;

   logic                 cke;
   logic                 csN;
   logic                 rasN;
   logic                 casN;
   logic                 weN;
   logic                 spareRx;
   logic                 mirrorSelect;
   logic [BANK_W-1:0]    bankSelect;
   logic [ADDR_W-1:0]    addr;
   logic [MASK_W-1:0]    writeByteMask;
   logic [STRB_W-1:0]    writeStrobe;
   logic [STRB_W-1:0]    readStrobe;
   logic [PAIR_W-1:0]    dqCtrl;
   logic                 dqCtrlOe;
   logic [PAIR_W-1:0]    dqDev;
   logic                 dqDevOe;
   logic [PAIR_W-1:0]    dqBus;

   // shared data wire, resolved from the two enables
   assign dqBus = dqDevOe ? dqDev : (dqCtrlOe ? dqCtrl : '0);

   modport dev (
      input  cke, csN, rasN, casN, weN, spareRx, mirrorSelect, bankSelect, addr,
      input  writeByteMask, writeStrobe, dqBus,
      output dqDev, dqDevOe, readStrobe
   );

   modport ctrl (
      output cke, csN, rasN, casN, weN, spareRx, mirrorSelect, bankSelect, addr,
      output writeByteMask, writeStrobe, dqCtrl, dqCtrlOe,
      input  dqBus, dqDevOe, readStrobe
   );
endinterface

// >>> rtl/gsd_device.sv
`timescale 1ns/10ps
module gsd_device
   import gsd_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rstn,
   gsd_link_if.dev                link,
   output logic [1:0]             powerState,
   output logic [ADDR_W-1:0]      modeWord0,
   output logic [ADDR_W-1:0]      modeWord1,
   output logic [BANKS-1:0]       openBankMask
);

   gsd_power_t                  pwr_r;
   gsd_power_t                  pwr_nxt;
   logic [BANKS-1:0]            rowOpen_r;
   logic [ADDR_W-1:0]           openRow_r [BANKS];
   logic [ADDR_W-1:0]           mode_r [2];
   logic                        wrPend_r;
   logic [MEM_IDX_W-1:0]        wrIdx_r;
   logic                        rdValid_r;
   logic [PAIR_W-1:0]           rdData_r;
   logic [BEAT_W-1:0]           mem [MEM_WORDS];

   // mirrored boards move the row strobe onto the spare ball
   wire        rowStrobeN = link.mirrorSelect ? link.spareRx : link.rasN;
   wire [3:0]  cmdCode    = {link.csN, rowStrobeN, link.casN, link.weN};
   wire        awake      = (pwr_r == GSD_PS_NORMAL);
   // buffers closed in power-down and while clock enable is low
   wire        cmdLive    = awake && link.cke && !link.csN;
   wire        isAct      = cmdLive && (cmdCode == CMD_ACT);
   wire        isRd       = cmdLive && (cmdCode == CMD_RD);
   wire        isWr       = cmdLive && (cmdCode == CMD_WR);
   wire        isPre      = cmdLive && (cmdCode == CMD_PRE);
   wire        isMrs      = cmdLive && (cmdCode == CMD_MRS);
   wire        allIdle    = (rowOpen_r == '0);
   // self refresh is a refresh code issued with clock enable already low
   wire        srEntry    = awake && !link.cke && !link.csN
                            && (cmdCode == CMD_REF) && allIdle;

   wire [BANK_W-1:0] bank   = link.bankSelect;
   wire [ADDR_W-1:0] colAdr = {2'h0, link.addr[COL_HI_BIT], 1'b0,
                               link.addr[7:0]};
   wire              autoPre = link.addr[SCOPE_BIT];
   wire              preAll  = link.addr[SCOPE_BIT];
   wire [MEM_IDX_W-1:0] accIdx = gsd_mem_index(bank, openRow_r[bank], colAdr);
   wire              bankOk  = rowOpen_r[bank];

   // power state walk, clock enable sampled on the rising edge
   always_comb begin
      pwr_nxt = pwr_r;
      case (pwr_r)
         GSD_PS_NORMAL: begin
            if (!link.cke) begin
               if (srEntry) begin
                  pwr_nxt = GSD_PS_SELF_REF;
               end else if (!allIdle) begin
                  pwr_nxt = GSD_PS_ACT_PD;
               end else begin
                  pwr_nxt = GSD_PS_PRE_PD;
               end
            end
         end
         GSD_PS_PRE_PD, GSD_PS_ACT_PD: begin
            if (link.cke) begin
               pwr_nxt = GSD_PS_NORMAL;
            end
         end
         GSD_PS_SELF_REF: begin
            // no clock-stable qualifier: the clock may have been stopped
            if (link.cke) begin
               pwr_nxt = GSD_PS_NORMAL;
            end
         end
         default: pwr_nxt = GSD_PS_NORMAL;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pwr_r <= GSD_PS_NORMAL;
      end else begin
         pwr_r <= pwr_nxt;
      end
   end

   // per-bank row tracking; rows survive power-down untouched
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rowOpen_r <= '0;
         for (int b = 0; b < BANKS; b++) begin
            openRow_r[b] <= '0;
         end
      end else if (isAct) begin
         rowOpen_r[bank] <= 1'b1;
         openRow_r[bank] <= link.addr;
      end else if (isPre) begin
         if (preAll) begin
            rowOpen_r <= '0;
         end else begin
            rowOpen_r[bank] <= 1'b0;
         end
      end else if ((isRd || isWr) && autoPre) begin
         rowOpen_r[bank] <= 1'b0;
      end
   end

   // mode words, bank select bit 0 picks which one
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         mode_r[0] <= MODE_RST;
         mode_r[1] <= MODE_RST;
      end else if (isMrs) begin
         mode_r[bank[0]] <= link.addr;
      end
   end

   // write data follows its command by one clock
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wrPend_r <= 1'b0;
         wrIdx_r  <= '0;
      end else begin
         wrPend_r <= isWr && bankOk;
         wrIdx_r  <= accIdx;
      end
   end

   // storage, both beats land in one edge with their own byte masks
   always_ff @(posedge ref_clk) begin
      if (wrPend_r) begin
         for (int y = 0; y < 4; y++) begin
            if (!link.writeByteMask[y]) begin
               mem[wrIdx_r][8*y +: 8] <= link.dqBus[8*y +: 8];
            end
            if (!link.writeByteMask[4+y]) begin
               mem[wrIdx_r | 7'h01][8*y +: 8] <= link.dqBus[BEAT_W + 8*y +: 8];
            end
         end
      end
   end

   // read pair launched the clock after the command
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rdValid_r <= 1'b0;
         rdData_r  <= '0;
      end else begin
         rdValid_r <= isRd && bankOk;
         if (isRd && bankOk) begin
            rdData_r <= {mem[accIdx | 7'h01], mem[accIdx]};
         end
      end
   end

   // drivers follow clock enable; strobe toggles with each beat
   assign link.dqDevOe    = rdValid_r && link.cke;
   assign link.dqDev      = rdData_r;
   assign link.readStrobe = link.dqDevOe ? STRB_BEAT : '0;

   assign powerState   = pwr_r;
   assign modeWord0    = mode_r[0];
   assign modeWord1    = mode_r[1];
   assign openBankMask = rowOpen_r;

endmodule

// >>> test/gsd_link_properties.sv
`timescale 1ns/10ps
module gsd_link_properties
   import gsd_pkg::*;
(
   input wire logic              ref_clk,
   input wire logic              rstn,
   input wire logic              cke,
   input wire logic              csN,
   input wire logic              rasN,
   input wire logic              casN,
   input wire logic              weN,
   input wire logic              spareRx,
   input wire logic              mirrorSelect,
   input wire logic [BANK_W-1:0] bankSelect,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [STRB_W-1:0] writeStrobe,
   input wire logic [STRB_W-1:0] readStrobe,
   input wire logic              dqCtrlOe,
   input wire logic              dqDevOe
);
   // row strobe moves to the spare receiver when the strap mirrors the pins
   wire       rowStrobeN = mirrorSelect ? spareRx : rasN;
   wire [3:0] cmd        = {csN, rowStrobeN, casN, weN};
   wire       isRd       = cke && (cmd == CMD_RD);
   wire       isWr       = cke && (cmd == CMD_WR);
   wire       isAccess   = isRd || isWr;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   // write data phase: one strobed beat pair, then the bus is let go
   sequence s_wrBeat;
      dqCtrlOe && (writeStrobe == STRB_BEAT) ##1 !dqCtrlOe;
   endsequence

   // device answer: one strobed pair right after the read
   sequence s_rdBeat;
      dqDevOe && (readStrobe == STRB_BEAT) ##1 !dqDevOe;
   endsequence

   a_read_answer: assert property (isRd |=> s_rdBeat)
      else $error("read pair missing after read command");
   a_answer_cause: assert property (dqDevOe |-> $past(isRd))
      else $error("device drove data without a read");
   a_write_beat: assert property (isWr |=> s_wrBeat)
      else $error("write beat not one strobed cycle");
   a_write_cause: assert property (dqCtrlOe |-> $past(isWr))
      else $error("controller drove data without a write");
   a_act_first: assert property (isAccess |-> $past(cmd) == CMD_ACT && $stable(bankSelect))
      else $error("access not preceded by activate of same bank");
   a_auto_precharge: assert property (isAccess |-> addr[SCOPE_BIT])
      else $error("access without auto-precharge flag");
   a_cke_held: assert property (isAccess |-> cke [*2])
      else $error("clock enable dropped during access");
   a_spare_quiet: assert property (mirrorSelect ? !rasN : !spareRx)
      else $error("unused mirrored receiver not held low");
   a_bus_single: assert property (!(dqDevOe && dqCtrlOe))
      else $error("both ends drive the data bus");
   a_pd_quiet: assert property (!cke |-> !dqDevOe ##1 !dqDevOe)
      else $error("device drives data with clock enable low");
endmodule

// >>> test/sdram_pin_command_interface_tb.sv
`timescale 1ns/10ps
module sdram_pin_command_interface_tb;
   import gsd_pkg::*;
   logic              ref_clk        = 1'b0;
   logic              rstn           = 1'b0;
   logic              mirrorStrap    = 1'b0;
   logic              reqValid       = 1'b0;
   logic              reqWrite       = 1'b0;
   logic [BANK_W-1:0] reqBank        = '0;
   logic [ADDR_W-1:0] reqRow         = '0;
   logic [8:0]        reqCol         = '0;
   logic [PAIR_W-1:0] reqWData       = '0;
   logic [MASK_W-1:0] reqMask        = '0;
   logic              rdReady        = 1'b0;
   logic              powerDownReq   = 1'b0;
   logic              selfRefreshReq = 1'b0;
   logic              reqReady;
   logic              rdValid;
   logic              busy;
   logic [PAIR_W-1:0] rdData;
   logic [1:0]        powerState;
   logic [ADDR_W-1:0] modeWord0;
   logic [BANKS-1:0]  openBankMask;
   int                errors         = 0;
   int                nTests         = 0;
   int                seed           = 32'h979d;
   logic [PAIR_W-1:0] model [0:63];
   logic [ADDR_W-1:0] rows  [0:3];
   logic [8:0]        cols  [0:3];

   always #25 ref_clk = ~ref_clk;

   gsd_link_if link (.ref_clk(ref_clk));

   gsd_device gsd_device_inst (.ref_clk(ref_clk), .rstn(rstn), .link(link),
      .powerState(powerState), .modeWord0(modeWord0), .modeWord1(),
      .openBankMask(openBankMask));

   gsd_controller gsd_controller_inst (.ref_clk(ref_clk), .rstn(rstn), .link(link),
      .mirrorStrap(mirrorStrap), .reqValid(reqValid), .reqReady(reqReady),
      .reqWrite(reqWrite), .reqBank(reqBank), .reqRow(reqRow), .reqCol(reqCol),
      .reqWData(reqWData), .reqMask(reqMask), .rdValid(rdValid), .rdReady(rdReady),
      .rdData(rdData), .powerDownReq(powerDownReq), .selfRefreshReq(selfRefreshReq),
      .busy(busy));

   gsd_link_properties gsd_link_properties_inst (.ref_clk(ref_clk), .rstn(rstn),
      .cke(link.cke), .csN(link.csN), .rasN(link.rasN), .casN(link.casN),
      .weN(link.weN), .spareRx(link.spareRx), .mirrorSelect(link.mirrorSelect),
      .bankSelect(link.bankSelect), .addr(link.addr), .writeStrobe(link.writeStrobe),
      .readStrobe(link.readStrobe), .dqCtrlOe(link.dqCtrlOe), .dqDevOe(link.dqDevOe));

   // storage slot of a bank's chosen row and column, aliasing as the array does
   function automatic int key(input int b);
      key = {b[1:0], rows[b][1:0], cols[b][2:1]};
   endfunction

   // masked bytes keep the old contents
   function automatic logic [63:0] merge(input logic [63:0] old, nw, input logic [7:0] m);
      for (int j = 0; j < 8; j++) merge[8*j +: 8] = m[j] ? old[8*j +: 8] : nw[8*j +: 8];
   endfunction

   task automatic give_verdict();
      $display("errors=%0d comparisons=%0d", errors, nTests);
      if (errors == 0 && nTests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [63:0] seen, exp);
      nTests++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // hold the request until the edge that samples ready high
   task automatic req(input logic w, input int b, input logic [63:0] d, input logic [7:0] m);
      int i;
      @(posedge ref_clk);
      #1;
      {reqValid, reqWrite, reqBank, reqRow, reqCol} = {1'b1, w, b[1:0], rows[b], cols[b]};
      {reqWData, reqMask} = {d, m};
      for (i = 0; i < 40; i++) begin
         @(negedge ref_clk);
         if (reqReady === 1'b1) break;
      end
      if (reqReady !== 1'b1) begin
         errors++;
         give_verdict();
      end
      @(posedge ref_clk);
      #1 reqValid = 1'b0;
      // activate lands on the next edge, auto-precharge closes it one later
      repeat (2) @(negedge ref_clk);
      chk(openBankMask, BANKS'(1) << b);
   endtask

   task automatic pop(input logic [63:0] exp);
      int i;
      @(posedge ref_clk);
      #1 rdReady = 1'b1;
      for (i = 0; i < 40; i++) begin
         @(negedge ref_clk);
         if (rdValid === 1'b1) break;
      end
      chk(rdValid, 1'b1);
      chk(rdData, exp);
      @(posedge ref_clk);
      #1 rdReady = 1'b0;
   endtask

   task automatic doReset(input logic mir);
      @(posedge ref_clk);
      #1 {rstn, mirrorStrap} = {1'b0, mir};
      repeat (6) @(posedge ref_clk);
      #1 rstn = 1'b1;
      @(negedge ref_clk);
      chk(modeWord0, MODE_RST);
      // start-up mode set is driven on edge 1 and taken on edge 2
      repeat (2) @(negedge ref_clk);
      chk(modeWord0, INIT_OP);
      chk(openBankMask, '0);
   endtask

   // request a low-power state, then leave it again
   task automatic powerCase(input logic sr, input logic [1:0] want);
      int i;
      @(posedge ref_clk);
      #1 {powerDownReq, selfRefreshReq} = {!sr, sr};
      for (i = 0; i < 30 && powerState !== want; i++) @(negedge ref_clk);
      chk(powerState, want);
      chk(reqReady, 1'b0);
      @(posedge ref_clk);
      #1 {powerDownReq, selfRefreshReq} = 2'b00;
      for (i = 0; i < 30 && powerState !== GSD_PS_NORMAL; i++) @(negedge ref_clk);
      chk(powerState, GSD_PS_NORMAL);
   endtask

   initial begin
      logic [63:0] d;
      logic [7:0]  m;
      // one pass per strap value; the second reset lands mid-run
      for (int p = 0; p < 2; p++) begin
         doReset(p[0]);
         for (int b = 0; b < 4; b++) begin
            rows[b] = ADDR_W'($random(seed));
            cols[b] = 9'($random(seed)) & 9'h1fe;
            d = {$random(seed), $random(seed)};
            req(1'b1, b, d, 8'h00);
            model[key(b)] = d;
            d = {$random(seed), $random(seed)};
            m = (b == 0) ? 8'hff : (b == 3) ? 8'h00 : 8'($random(seed));
            req(1'b1, b, d, m);
            model[key(b)] = merge(model[key(b)], d, m);
         end
         for (int b = 0; b < 4; b++) begin
            req(1'b0, b, '0, '0);
            pop(model[key(b)]);
         end
         $display("test traffic mirror=%0d done", p);
      end
      // reader stalls: the fifo fills and refuses a fifth read
      for (int b = 0; b < 4; b++) req(1'b0, b, '0, '0);
      @(posedge ref_clk);
      #1 {reqValid, reqWrite, reqBank} = {1'b1, 1'b0, 2'h0};
      repeat (8) @(negedge ref_clk);
      chk(reqReady, 1'b0);
      @(posedge ref_clk);
      #1 reqValid = 1'b0;
      for (int b = 0; b < 4; b++) pop(model[key(b)]);
      @(negedge ref_clk);
      chk(rdValid, 1'b0);
      $display("test fifo fill done");
      powerCase(1'b0, GSD_PS_PRE_PD);
      powerCase(1'b1, GSD_PS_SELF_REF);
      req(1'b0, 1, '0, '0);
      pop(model[key(1)]);
      $display("test power states done");
      give_verdict();
   end
endmodule
